// ===== ssp_core.sv
// ssp_core: serial port holding buffers, status flags, control and pins
// assumes: ahb-lite single master, word transfers, pins synchronised here
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`default_nettype none
module ssp_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins
  input wire ssp_pkg::ssp_pin_in_type pin_in,
  output ssp_pkg::ssp_pin_out_type pin_out,
  // interrupt
  output logic irq
);
  import ssp_pkg::*;

  typedef enum {ST_IDLE, ST_SHIFT} ssp_state_type;

  // synchronised pins
  ssp_pin_in_type pin_s;
  ssp_sync #(.W(3)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_in),
    .q(pin_s)
  );

  function automatic logic is_sel(input logic [11:0] a, input logic [11:0] off);
    is_sel = (a == off);
  endfunction

  // bus address phase capture
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [11:0] addr_reg, addr_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] txb_reg, txb_next, rxb_reg, rxb_next, sr_reg, sr_next;
  logic tbf_reg, tbf_next, rbf_reg, rbf_next, rov_reg, rov_next;
  logic [2:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  ssp_state_type st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] div_reg, div_next;
  logic sck_reg, sck_next, sdo_reg, sdo_next, sck_prev_reg;
  logic [15:0] ctrl_w;
  logic wr_buf, rd_buf, lead, trail, master, wide, rx_done, tx_load;
  logic [4:0] nbits;
  logic active_lvl;

  assign master = ctrl_reg[SSP_BIT_MASTER];
  assign wide = ctrl_reg[SSP_BIT_WIDTH];
  assign nbits = wide ? 5'd16 : 5'd8; // RULE_07
  assign wr_buf = wr_reg && is_sel(addr_reg, SSP_OFF_BUFFER);
  assign rd_buf = rd_reg && is_sel(addr_reg, SSP_OFF_BUFFER);
  assign ctrl_w = hwdata[15:0];

  // edge finding on clock level: own divider in master, pin in slave
  logic sck_now, sck_idle;
  assign sck_idle = ctrl_reg[SSP_BIT_POL];
  // registered level in master, so no loop through the done check
  assign sck_now = master ? sck_reg : pin_s.sck_in;
  assign active_lvl = ~sck_idle;
  assign lead = (sck_now != sck_prev_reg) && (sck_now == active_lvl);
  assign trail = (sck_now != sck_prev_reg) && (sck_now == sck_idle);

  always_comb begin
    wr_next = 1'b0;
    rd_next = 1'b0;
    addr_next = addr_reg;
    if (hsel && hready && htrans[1]) begin
      wr_next = hwrite;
      rd_next = !hwrite;
      addr_next = haddr;
    end
  end

  // shift engine
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    div_next = div_reg;
    sck_next = sck_reg;
    sdo_next = sdo_reg;
    tx_load = 1'b0;
    rx_done = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        sck_next = sck_idle;
        div_next = 8'h00;
        if (tbf_reg && (master || !pin_s.ss_n || !ctrl_reg[SSP_BIT_SEL_EN])) begin
          tx_load = 1'b1; // RULE_03
          sr_next = wide ? txb_reg : {txb_reg[7:0], 8'h00}; // RULE_07
          sdo_next = wide ? txb_reg[15] : txb_reg[7];
          cnt_next = 5'd0;
          st_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (master) begin
          if (div_reg == SSP_HALF_DIV - 8'h01) begin
            div_next = 8'h00;
            sck_next = ~sck_reg;
          end else begin
            div_next = div_reg + 8'h01;
          end
        end
        if (lead) begin
          sr_next = {sr_reg[14:0], pin_s.sdi};
          cnt_next = cnt_reg + 5'd1;
        end
        if (trail) begin
          sdo_next = sr_reg[15];
          if (cnt_reg == nbits) begin
            rx_done = 1'b1;
            sck_next = sck_idle;
            st_next = ST_IDLE;
          end
        end
      end
    endcase
  end

  // buffers, flags, registers
  always_comb begin
    ctrl_next = ctrl_reg;
    txb_next = txb_reg;
    rxb_next = rxb_reg;
    tbf_next = tbf_reg;
    rbf_next = rbf_reg;
    rov_next = rov_reg;
    ist_next = ist_reg;
    imask_next = imask_reg;
    if (wr_reg && is_sel(addr_reg, SSP_OFF_CTRL1)) begin
      ctrl_next = ctrl_w & SSP_CTRL1_MASK;
    end
    if (wr_reg && is_sel(addr_reg, SSP_OFF_STATUS) && ctrl_w[SSP_BIT_ROV]) begin
      rov_next = 1'b0;
    end
    if (wr_reg && is_sel(addr_reg, SSP_OFF_IRQ_MASK)) begin
      imask_next = hwdata[2:0];
    end
    if (wr_reg && is_sel(addr_reg, SSP_OFF_IRQ_STATUS)) begin
      ist_next = ist_reg & ~hwdata[2:0];
    end
    if (tx_load) begin
      tbf_next = 1'b0; // RULE_03
      ist_next[SSP_IRQ_TX] = 1'b1;
    end
    if (wr_buf) begin
      txb_next = wide ? ctrl_w : {8'h00, ctrl_w[7:0]};
      tbf_next = 1'b1; // RULE_02
    end
    if (rd_buf) begin
      rbf_next = 1'b0; // RULE_04
    end
    if (rx_done) begin
      if (rbf_reg && !rd_buf) begin
        rov_next = 1'b1; // RULE_01
        ist_next[SSP_IRQ_OVF] = 1'b1;
      end else begin
        rxb_next = wide ? sr_next : {8'h00, sr_next[7:0]};
        rbf_next = 1'b1; // RULE_04
        ist_next[SSP_IRQ_RX] = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      // next values, so a read right behind a write sees the new data
      if (is_sel(haddr, SSP_OFF_STATUS)) begin
        rdata_next[SSP_BIT_ROV] = rov_next;
        rdata_next[SSP_BIT_TBF] = tbf_next;
        rdata_next[SSP_BIT_RBF] = rbf_next;
      end else if (is_sel(haddr, SSP_OFF_CTRL1)) begin
        rdata_next[15:0] = ctrl_next;
      end else if (is_sel(haddr, SSP_OFF_BUFFER)) begin
        rdata_next[15:0] = rxb_next;
      end else if (is_sel(haddr, SSP_OFF_IRQ_STATUS)) begin
        rdata_next[2:0] = ist_next;
      end else if (is_sel(haddr, SSP_OFF_IRQ_MASK)) begin
        rdata_next[2:0] = imask_next;
      end
    end
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 12'h000;
      ctrl_reg <= SSP_CTRL1_RESET;
      txb_reg <= SSP_DATA_RESET;
      rxb_reg <= SSP_DATA_RESET;
      sr_reg <= SSP_DATA_RESET;
      tbf_reg <= 1'b0;
      rbf_reg <= 1'b0;
      rov_reg <= 1'b0;
      ist_reg <= SSP_IRQ_RESET;
      imask_reg <= SSP_IRQ_RESET;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      st_reg <= ST_IDLE;
      cnt_reg <= 5'd0;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      txb_reg <= txb_next;
      rxb_reg <= rxb_next;
      sr_reg <= sr_next;
      tbf_reg <= tbf_next;
      rbf_reg <= rbf_next;
      rov_reg <= rov_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      sck_prev_reg <= sck_now;
    end
  end

  // pin drive registers
  ssp_pin_out_type pout_reg, pout_next;
  always_comb begin
    pout_next.sck_out = sck_next;
    pout_next.sck_oe = master && !ctrl_next[SSP_BIT_CLK_PIN_DIS]; // RULE_05
    pout_next.sdo = sdo_next;
    pout_next.sdo_oe = !ctrl_next[SSP_BIT_OUT_PIN_DIS]; // RULE_06
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pout_reg <= '0;
    end else begin
      pout_reg <= pout_next;
    end
  end

  assign pin_out = pout_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign irq = irq_reg;
endmodule // ssp_core
`default_nettype wire

// ===== ssp_pkg.sv
// ssp_pkg: shared constants and types for the serial port buffer/status block
// assumes: one clock hclk at 10 MHz, ahb-lite register access
// Function
// RULE_01: overflow discards new data, sets status bit 6
// RULE_02: buffer write sets transmit full bit 1
// RULE_03: move to shift register clears transmit full
// RULE_04: receive full bit 0 set, cleared on read
// RULE_05: master clock pin disable bit 12
// RULE_06: data out pin disable bit 11
// RULE_07: width select picks 16 or 8 bits
// RULE_08: software avoids both prescalers at 1:1
`default_nettype none
package ssp_pkg;
  localparam logic [11:0] SSP_OFF_STATUS = 12'h000;
  localparam logic [11:0] SSP_OFF_CTRL1 = 12'h004;
  localparam logic [11:0] SSP_OFF_BUFFER = 12'h008;
  localparam logic [11:0] SSP_OFF_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] SSP_OFF_IRQ_MASK = 12'h010;
  localparam int SSP_BIT_ROV = 6;
  localparam int SSP_BIT_TBF = 1;
  localparam int SSP_BIT_RBF = 0;
  localparam int SSP_BIT_CLK_PIN_DIS = 12;
  localparam int SSP_BIT_OUT_PIN_DIS = 11;
  localparam int SSP_BIT_WIDTH = 10;
  localparam int SSP_BIT_SAMPLE = 9;
  localparam int SSP_BIT_SEL_EN = 7;
  localparam int SSP_BIT_EDGE = 8;
  localparam int SSP_BIT_POL = 6;
  localparam int SSP_BIT_MASTER = 5;
  localparam logic [15:0] SSP_CTRL1_MASK = 16'h1fff;
  localparam logic [15:0] SSP_CTRL1_RESET = 16'h0000;
  localparam int SSP_IRQ_RX = 0;
  localparam int SSP_IRQ_TX = 1;
  localparam int SSP_IRQ_OVF = 2;
  localparam logic [2:0] SSP_IRQ_RESET = 3'h0;
  localparam logic [15:0] SSP_DATA_RESET = 16'h0000;
  localparam logic [7:0] SSP_HALF_DIV = 8'h04;
  typedef struct packed {
    logic sck_in;
    logic sdi;
    logic ss_n;
  } ssp_pin_in_type;
  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
  } ssp_pin_out_type;
endpackage // ssp_pkg
`default_nettype wire

// ===== ssp_sync.sv
// ssp_sync: two flip-flop level synchroniser, width parameter
// assumes: input asynchronous to hclk
`default_nettype none
module ssp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // ssp_sync
`default_nettype wire

// ===== ssp_core_properties.sv
// checker for ssp_core: control pins, status reads, irq
// assumes: ahb-lite single master, bound to ssp_core
`default_nettype none
module ssp_core_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins and irq
  input wire ssp_pkg::ssp_pin_in_type pin_in,
  input wire ssp_pkg::ssp_pin_out_type pin_out,
  input wire logic irq
);
  import ssp_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic v_reg;
  logic w_reg;
  logic [11:0] a_reg;
  logic [15:0] c_reg;
  logic [15:0] m_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v_reg <= 1'b0;
      c_reg <= '0;
      m_reg <= '0;
    end else begin
      v_reg <= hsel && hready && htrans[1];
      if (v_reg && w_reg && a_reg == SSP_OFF_CTRL1) c_reg <= hwdata[15:0];
      if (v_reg && w_reg && a_reg == SSP_OFF_IRQ_MASK) m_reg <= hwdata[15:0];
    end
  end
  always_ff @(posedge hclk) begin
    a_reg <= haddr;
    w_reg <= hwrite;
  end
  property p_sck_off;
    (c_reg[SSP_BIT_MASTER] && c_reg[SSP_BIT_CLK_PIN_DIS])[*4] |-> !pin_out.sck_oe;
  endproperty
  a_sck_off: assert property (p_sck_off) else $error("clock pin driven");
  property p_sck_on;
    (c_reg[SSP_BIT_MASTER] && !c_reg[SSP_BIT_CLK_PIN_DIS])[*4] |-> pin_out.sck_oe;
  endproperty
  a_sck_on: assert property (p_sck_on) else $error("clock pin released");
  property p_sdo_off;
    c_reg[SSP_BIT_OUT_PIN_DIS][*4] |-> !pin_out.sdo_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("data pin driven");
  property p_tx_start;
    v_reg && w_reg && a_reg == SSP_OFF_BUFFER && c_reg[SSP_BIT_MASTER]
      |-> ##[1:80] $changed(pin_out.sck_out);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit never began");
  property p_stat_zero;
    v_reg && !w_reg && a_reg == SSP_OFF_STATUS |-> hrdata[31:7] == 0 && hrdata[5:2] == 0;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
  property p_ctrl_rb;
    v_reg && !w_reg && a_reg == SSP_OFF_CTRL1 |-> hrdata[15:0] == (c_reg & SSP_CTRL1_MASK);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_unmapped;
    v_reg && !w_reg && a_reg > SSP_OFF_IRQ_MASK |-> hrdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_quiet;
    (m_reg[2:0] == 3'h0)[*3] |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("masked irq raised");
  c_irq: cover property (irq);
  c_sck: cover property (pin_out.sck_oe && $changed(pin_out.sck_out));
  c_ovf: cover property (v_reg && !w_reg && a_reg == SSP_OFF_STATUS && hrdata[6]);
endmodule // ssp_core_properties
bind ssp_core ssp_core_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
`default_nettype wire

// ===== ssp_peer.sv
// serial peer: slave answering the block's master clock
// assumes: msb first, data changed on falling sck, idle low
// captures the block's data-out bits on rising sck
`default_nettype none
module ssp_peer (
  // control
  input wire logic rst_n,
  input wire logic wide,
  input wire logic [15:0] pattern,
  // pins
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic ss_n,
  // captured data-out bits
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt = 5'h0;
  logic odd = 1'b0;
  logic [15:0] shown;
  logic [15:0] cap = 16'h0000;
  assign ss_n = 1'b0;
  assign shown = pattern ^ {16{odd}};
  assign sdi = shown[(wide ? 5'd15 : 5'd7) - cnt];
  assign got = cap;
  always @(posedge sck) begin
    cap <= {cap[14:0], sdo};
  end
  always @(negedge sck) begin
    if (rst_n && cnt == (wide ? 5'd15 : 5'd7)) begin
      cnt <= 5'h0;
      odd <= ~odd;
    end else if (rst_n) begin
      cnt <= cnt + 5'h1;
    end
  end
endmodule // ssp_peer
`default_nettype wire

// ===== tb.sv
// testbench for ssp_core: bus tasks, serial peer, reference flags
// assumes: ssp_core, ssp_peer and the checker compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic wide = 1'b0;
  logic [15:0] pat = '0;
  logic hreadyout, hresp, irq, sdi_w, ss_w;
  logic [31:0] hrdata, rd;
  logic [15:0] got;
  ssp_pin_out_type pin_out;
  int failures = 0;
  int cmp_count = 0;
  int k = 0;
  int e_rbf = 0;
  int e_rov = 0;
  int e_rx = 0;
  logic [11:0] offs[6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h0fc};
  always #50 hclk = ~hclk;
  ssp_core u_ssp_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in({pin_out.sck_out, sdi_w, ss_w}), .pin_out(pin_out), .irq(irq));
  ssp_peer u_ssp_peer (.rst_n(hresetn), .wide(wide), .pattern(pat), .sck(pin_out.sck_out),
    .sdo(pin_out.sdo), .sdi(sdi_w), .ss_n(ss_w), .got(got));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_bit(input int b);
    rd = '0;
    while (rd[b] !== 1'b1) xfer(1'b0, SSP_OFF_STATUS, '0);
  endtask
  function automatic void frame_done(input int w);
    k++;
    if (e_rbf == 1) e_rov = 1;
    else begin
      e_rx = (pat ^ {16{~k[0]}}) & (w == 1 ? 16'hffff : 16'h00ff);
      e_rbf = 1;
    end
  endfunction
  task automatic give_verdict;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    failures++;
    give_verdict();
  end
  initial begin
    logic [15:0] cv;
    void'($urandom(32'h762a));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (offs[i]) begin
      xfer(1'b0, offs[i], '0);
      chk("reset read", rd, '0);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cv = {3'h0, i[1], i[0], 11'h020} | (16'($urandom) & 16'h0280);
      xfer(1'b1, SSP_OFF_CTRL1, {16'h0, cv});
      xfer(1'b0, SSP_OFF_CTRL1, '0);
      chk("ctrl1", rd, {16'h0, cv & SSP_CTRL1_MASK});
      chk("sck_oe", pin_out.sck_oe, !i[1]);
      chk("sdo_oe", pin_out.sdo_oe, !i[0]);
    end
    $display("test pins done");
    xfer(1'b1, SSP_OFF_CTRL1, 32'h0000_0020);
    xfer(1'b1, SSP_OFF_IRQ_MASK, 32'h0000_0007);
    pat <= 16'($urandom);
    xfer(1'b1, SSP_OFF_BUFFER, 32'h0000_00a5);
    xfer(1'b1, SSP_OFF_BUFFER, 32'h0000_005a);
    xfer(1'b0, SSP_OFF_STATUS, '0);
    chk("tx full", rd[SSP_BIT_TBF], 1'b1);
    wait_bit(SSP_BIT_RBF);
    frame_done(0);
    wait_bit(SSP_BIT_ROV);
    frame_done(0);
    chk("status", rd, 32'(e_rov * 64 + e_rbf));
    chk("tx bytes", {16'h0000, got}, 32'h0000_a55a);
    chk("irq", irq, 1'b1);
    xfer(1'b1, SSP_OFF_IRQ_MASK, '0);
    @(posedge hclk);
    chk("irq masked", irq, 1'b0);
    xfer(1'b0, SSP_OFF_BUFFER, '0);
    e_rbf = 0;
    chk("rx data", rd, 32'(e_rx));
    xfer(1'b1, SSP_OFF_STATUS, 32'h0000_0040);
    e_rov = 0;
    xfer(1'b0, SSP_OFF_STATUS, '0);
    chk("status clear", rd, 32'(e_rov * 64 + e_rbf));
    $display("test overflow done");
    xfer(1'b1, SSP_OFF_CTRL1, 32'h0000_0420);
    wide <= 1'b1;
    xfer(1'b1, SSP_OFF_BUFFER, 32'h0000_1234);
    wait_bit(SSP_BIT_RBF);
    frame_done(1);
    chk("tx word", {16'h0000, got}, 32'h0000_1234);
    xfer(1'b0, SSP_OFF_BUFFER, '0);
    chk("rx word", rd, 32'(e_rx));
    $display("test word done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
